// *** src/bridge_control_config.sv ***
// Bridge control and interrupt pin registers with their steering logic.
`timescale 1ns/1ns
`include "bridge_control_config_consts.svh"

module bridge_control_config #(
	parameter int DISCARD_LONG  = `BCC_DISCARD_LONG,
	parameter int DISCARD_SHORT = `BCC_DISCARD_SHORT
) (
	// Clock, reset and clock enable.
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Mode strap and command enables.
	input  wire logic        REVERSE_MODE,
	input  wire logic        IO_ENABLE,
	input  wire logic        MEM_ENABLE,
	input  wire logic        SERR_PIN_ENABLE,
	// Secondary system error pin, active low, from the bus.
	input  wire logic        SEC_SERR_N,
	// Error events from the datapath.
	input  wire logic        SEC_PARITY_ERR,
	input  wire logic        POISON_RX,
	input  wire logic        MASTER_ABORT,
	input  wire logic        MA_CAN_TARGET_ABORT,
	// Delayed completion handshake.
	input  wire logic        DC_READY,
	input  wire logic        DC_TAKEN,
	output logic             DC_DISCARD,
	// Address forwarding decode.
	input  wire logic [31:0] IO_ADDR,
	input  wire logic        IO_IN_WINDOW,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic        MEM_IN_WINDOW,
	output logic             IO_FORWARD,
	output logic             MEM_FORWARD,
	// Error responses.
	output logic             PARITY_RESPOND,
	output logic             MDPE_SET,
	output logic             ERR_MSG_REQ,
	output logic             TARGET_ABORT_REQ,
	output logic             MA_RETURN_ONES,
	output logic             MA_DISCARD_WRITE,
	output logic             SYSTEM_ERROR_PIN_N_O,
	output logic             SYSTEM_ERROR_PIN_N_OE,
	// Resets toward the secondary side.
	output logic             SEC_BUS_RESET_N,
	output logic             HOT_RESET,
	// Interrupt.
	output logic             IRQ
);

	// Register state.
	bridge_control_config_pkg::bctl_s   ctl_ff;
	bridge_control_config_pkg::bctl_s   nxt_ctl;
	bridge_control_config_pkg::irq_s    stat_ff;
	bridge_control_config_pkg::irq_s    nxt_stat;
	bridge_control_config_pkg::irq_s    mask_ff;
	bridge_control_config_pkg::irq_s    ev;
	bridge_control_config_pkg::dtimer_e dt_ff;
	bridge_control_config_pkg::dtimer_e nxt_dt;
	logic                               mto_ff;
	logic [15:0]                        dcnt_ff;
	logic [31:0]                        prdata_ff;
	logic                               rev_s1_ff;
	logic                               rev_ff;
	logic                               serr_s1_ff;
	logic                               serr_s2_ff;
	logic                               serr_s3_ff;
	logic                               perr_ff;
	logic                               mdpe_ff;
	logic                               errmsg_ff;
	logic                               tabort_ff;
	logic                               serr_out_ff;
	logic                               discard_ff;
	logic                               secrst_ff;
	logic                               hotrst_ff;

	// Bus decode.
	wire        setup    = PSEL && !PENABLE;
	wire        access   = PSEL && PENABLE;
	wire        hit_ctl  = (PADDR == `BCC_OFF_CTRL);
	wire        hit_stat = (PADDR == `BCC_OFF_IRQ_STATUS);
	wire        hit_mask = (PADDR == `BCC_OFF_IRQ_MASK);
	wire        hit_st   = (PADDR == `BCC_OFF_STATE);
	wire        mapped   = hit_ctl || hit_stat || hit_mask || hit_st;
	wire        wr_ctl   = access && PWRITE && hit_ctl;
	wire        wr_stat  = access && PWRITE && hit_stat;
	wire        wr_mask  = access && PWRITE && hit_mask;

	// Zero wait states; the read word is captured during setup.
	assign PREADY  = 1'b1;
	assign PSLVERR = access && !mapped;
	assign PRDATA  = prdata_ff;

	// Read view of the control word; read-only bits show fixed values.
	wire [7:0]  pin_val  = rev_ff ? `BCC_PIN_REVERSE
	                              : `BCC_PIN_FORWARD;
	wire        serr_rd  = ctl_ff.serr_fwd && !rev_ff;
	wire        pri_rd   = ctl_ff.pri_short && rev_ff;
	wire [31:0] ctl_word = {5'h00, mto_ff, 1'b0, pri_rd,
	                        1'b0,
	                        ctl_ff.sec_reset, ctl_ff.ma_mode,
	                        ctl_ff.vga16, ctl_ff.vga, ctl_ff.isa,
	                        serr_rd, ctl_ff.perr_resp,
	                        pin_val, ctl_ff.int_line};
	wire [31:0] state_wd = {30'h00000000, dt_ff == bridge_control_config_pkg::DT_RUN,
	                        rev_ff};
	wire [31:0] rd_mux   = hit_ctl  ? ctl_word :
	                       hit_stat ? {27'h0000000, stat_ff} :
	                       hit_mask ? {27'h0000000, mask_ff} :
	                       hit_st   ? state_wd : 32'h00000000;

	// Control write: bit 17 is frozen in reverse, bit 24 in forward.
	always_comb begin
		nxt_ctl = ctl_ff;
		if (wr_ctl) begin
			nxt_ctl.int_line  = PWDATA[7:0];
			nxt_ctl.perr_resp = PWDATA[`BCC_BIT_PERR_RESP];
			if (!rev_ff) begin
				nxt_ctl.serr_fwd = PWDATA[`BCC_BIT_SERR_FWD];
			end
			nxt_ctl.isa       = PWDATA[`BCC_BIT_ISA];
			nxt_ctl.vga       = PWDATA[`BCC_BIT_VGA];
			nxt_ctl.vga16     = PWDATA[`BCC_BIT_VGA16];
			nxt_ctl.ma_mode   = PWDATA[`BCC_BIT_MA_MODE];
			nxt_ctl.sec_reset = PWDATA[`BCC_BIT_SEC_RESET];
			if (rev_ff) begin
				nxt_ctl.pri_short = PWDATA[`BCC_BIT_PRI_SHORT];
			end
		end
	end

	// Bus-facing registers.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctl_ff    <= '0;
			mask_ff   <= '0;
			prdata_ff <= 32'h00000000;
		end else if (CE) begin
			ctl_ff <= nxt_ctl;
			if (wr_mask) begin
				mask_ff <= PWDATA[`BCC_IRQ_WIDTH-1:0];
			end
			if (setup) begin
				prdata_ff <= rd_mux;
			end
		end
	end

	// Mode strap and secondary error pin pass two flops before use.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rev_s1_ff  <= 1'b0;
			rev_ff     <= 1'b0;
			serr_s1_ff <= 1'b1;
			serr_s2_ff <= 1'b1;
			serr_s3_ff <= 1'b1;
		end else if (CE) begin
			rev_s1_ff  <= REVERSE_MODE;
			rev_ff     <= rev_s1_ff;
			serr_s1_ff <= SEC_SERR_N;
			serr_s2_ff <= serr_s1_ff;
			serr_s3_ff <= serr_s2_ff;
		end
	end

	// Discard timer length; forward mode always uses the long count.
	wire [15:0] dlen = (rev_ff && ctl_ff.pri_short)
	                   ? 16'(DISCARD_SHORT - 1)
	                   : 16'(DISCARD_LONG - 1);
	wire        dexp = (dt_ff == bridge_control_config_pkg::DT_RUN)
	                   && (dcnt_ff == dlen) && !DC_TAKEN;

	// Timer state: a ready completion restarts it, retrieval stops it.
	always_comb begin
		nxt_dt = dt_ff;
		case (dt_ff)
			bridge_control_config_pkg::DT_IDLE: begin
				if (DC_READY) begin
					nxt_dt = bridge_control_config_pkg::DT_RUN;
				end
			end
			bridge_control_config_pkg::DT_RUN: begin
				if (DC_READY) begin
					nxt_dt = bridge_control_config_pkg::DT_RUN;
				end else if (DC_TAKEN || dexp) begin
					nxt_dt = bridge_control_config_pkg::DT_IDLE;
				end
			end
			default: begin
				nxt_dt = bridge_control_config_pkg::DT_IDLE;
			end
		endcase
	end

	// Counter runs only while a completion waits.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			dt_ff   <= bridge_control_config_pkg::DT_IDLE;
			dcnt_ff <= 16'h0000;
		end else if (CE) begin
			dt_ff <= nxt_dt;
			if (DC_READY || nxt_dt == bridge_control_config_pkg::DT_IDLE) begin
				dcnt_ff <= 16'h0000;
			end else begin
				dcnt_ff <= dcnt_ff + 16'h0001;
			end
		end
	end

	// Events that set sticky status bits.
	wire serr_fall = serr_s3_ff && !serr_s2_ff;
	always_comb begin
		ev.discard      = dexp;
		ev.sec_parity   = SEC_PARITY_ERR && ctl_ff.perr_resp && !rev_ff;
		ev.poison       = POISON_RX && ctl_ff.perr_resp && rev_ff;
		ev.sec_serr     = serr_fall && !rev_ff;
		ev.master_abort = MASTER_ABORT;
	end

	// Write-one clears, but an event in the same cycle keeps the bit set.
	assign nxt_stat = (stat_ff & ~(wr_stat ? PWDATA[`BCC_IRQ_WIDTH-1:0]
	                                       : {`BCC_IRQ_WIDTH{1'b0}})) | ev;
	wire   mto_clr  = wr_ctl && PWDATA[`BCC_BIT_MTO_STAT];

	// Sticky status and the discard status bit of the control word.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			stat_ff <= '0;
			mto_ff  <= 1'b0;
		end else if (CE) begin
			stat_ff <= nxt_stat;
			mto_ff  <= dexp || (mto_ff && !mto_clr);
		end
	end

	assign IRQ = |(stat_ff & mask_ff);

	// Master abort reporting choices.
	wire ma_report = MASTER_ABORT && ctl_ff.ma_mode;
	wire ta_now    = ma_report && MA_CAN_TARGET_ABORT;
	wire serr_now  = ma_report && !MA_CAN_TARGET_ABORT
	                 && SERR_PIN_ENABLE;

	// Response pulses and held reset levels, all from flops.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			perr_ff     <= 1'b0;
			mdpe_ff     <= 1'b0;
			errmsg_ff   <= 1'b0;
			tabort_ff   <= 1'b0;
			serr_out_ff <= 1'b0;
			discard_ff  <= 1'b0;
			secrst_ff   <= 1'b0;
			hotrst_ff   <= 1'b0;
		end else if (CE) begin
			perr_ff     <= ev.sec_parity;
			mdpe_ff     <= ev.poison;
			errmsg_ff   <= ev.sec_serr && ctl_ff.serr_fwd;
			tabort_ff   <= ta_now;
			serr_out_ff <= serr_now;
			discard_ff  <= dexp;
			secrst_ff   <= ctl_ff.sec_reset && !rev_ff;
			hotrst_ff   <= ctl_ff.sec_reset && rev_ff;
		end
	end

	assign PARITY_RESPOND        = perr_ff;
	assign MDPE_SET              = mdpe_ff;
	assign ERR_MSG_REQ           = errmsg_ff;
	assign TARGET_ABORT_REQ      = tabort_ff;
	assign DC_DISCARD            = discard_ff;
	assign SEC_BUS_RESET_N       = !secrst_ff;
	assign HOT_RESET             = hotrst_ff;
	assign SYSTEM_ERROR_PIN_N_O  = 1'b0;
	assign SYSTEM_ERROR_PIN_N_OE = serr_out_ff;
	// Hidden aborts: datapath returns all ones and drops writes.
	assign MA_RETURN_ONES        = !ctl_ff.ma_mode;
	assign MA_DISCARD_WRITE      = !ctl_ff.ma_mode;

	// I/O decode: ISA mode drops the low 256 bytes of each 1KB block below 64KB.
	wire io_low   = IO_ADDR < `BCC_ISA_LIMIT;
	wire isa_hole = ctl_ff.isa && io_low
	                && (IO_ADDR[9:8] == 2'h0);
	wire vga_top  = ctl_ff.vga16 ? (IO_ADDR[31:10] == 22'h000000)
	                             : 1'b1;
	wire vga_io   = vga_top && ((IO_ADDR[9:0] >= 10'h3B0
	                && IO_ADDR[9:0] <= 10'h3BB)
	                || (IO_ADDR[9:0] >= 10'h3C0
	                && IO_ADDR[9:0] <= 10'h3DF));
	wire vga_mem  = (MEM_ADDR >= `BCC_VGA_MEM_LO)
	                && (MEM_ADDR <= `BCC_VGA_MEM_HI);

	// VGA ranges bypass both the windows and the ISA hole when enabled.
	assign IO_FORWARD  = IO_ENABLE && ((ctl_ff.vga && vga_io)
	                     || (IO_IN_WINDOW && !isa_hole));
	assign MEM_FORWARD = MEM_ENABLE && ((ctl_ff.vga && vga_mem)
	                     || MEM_IN_WINDOW);

endmodule

// *** src/bridge_control_config_consts.svh ***
// Offsets, field positions, reset values and counts of the bridge control block.
`ifndef BRIDGE_CONTROL_CONFIG_CONSTS_SVH
`define BRIDGE_CONTROL_CONFIG_CONSTS_SVH

// Register byte offsets.
`define BCC_OFF_CTRL       12'h03C
`define BCC_OFF_IRQ_STATUS 12'h100
`define BCC_OFF_IRQ_MASK   12'h104
`define BCC_OFF_STATE      12'h108

// Field positions inside the control word.
`define BCC_BIT_PERR_RESP  16
`define BCC_BIT_SERR_FWD   17
`define BCC_BIT_ISA        18
`define BCC_BIT_VGA        19
`define BCC_BIT_VGA16      20
`define BCC_BIT_MA_MODE    21
`define BCC_BIT_SEC_RESET  22
`define BCC_BIT_PRI_SHORT  24
`define BCC_BIT_MTO_STAT   26

// Reset and fixed values.
`define BCC_PIN_FORWARD    8'h00
`define BCC_PIN_REVERSE    8'h01
`define BCC_ALL_ONES       32'hFFFFFFFF
`define BCC_IRQ_WIDTH      5

// Discard timer lengths in clock cycles.
`define BCC_DISCARD_LONG   32768
`define BCC_DISCARD_SHORT  1024

// Address decode constants.
`define BCC_ISA_LIMIT      32'h00010000
`define BCC_VGA_MEM_LO     32'h000A0000
`define BCC_VGA_MEM_HI     32'h000BFFFF

`endif

// *** src/bridge_control_config_pkg.sv ***
// Types shared by the bridge control block.
package bridge_control_config_pkg;

	// Writable control fields held by the block.
	typedef struct packed {
		logic       pri_short;
		logic       sec_reset;
		logic       ma_mode;
		logic       vga16;
		logic       vga;
		logic       isa;
		logic       serr_fwd;
		logic       perr_resp;
		logic [7:0] int_line;
	} bctl_s;

	// Sticky event bits, in status register order.
	typedef struct packed {
		logic master_abort;
		logic sec_serr;
		logic poison;
		logic sec_parity;
		logic discard;
	} irq_s;

	// Discard timer states.
	typedef enum logic [0:0] {
		DT_IDLE,
		DT_RUN
	} dtimer_e;

endpackage

// *** verif/bridge_control_config_checker.sv ***
// Port-level assertions for the bridge control block.
`timescale 1ns/1ns
module bridge_control_config_checker (
	// Clock and reset.
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	// Register bus.
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PSLVERR,
	// Strap, events and responses.
	input wire logic        REVERSE_MODE,
	input wire logic        SERR_PIN_ENABLE,
	input wire logic        SEC_PARITY_ERR,
	input wire logic        POISON_RX,
	input wire logic        MASTER_ABORT,
	input wire logic        MA_CAN_TARGET_ABORT,
	input wire logic        PARITY_RESPOND,
	input wire logic        MDPE_SET,
	input wire logic        TARGET_ABORT_REQ,
	input wire logic        MA_RETURN_ONES,
	input wire logic        SYSTEM_ERROR_PIN_N_OE,
	input wire logic        SEC_BUS_RESET_N,
	input wire logic        HOT_RESET,
	input wire logic        DC_DISCARD
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	// A completed write to the control word; levels are checked two edges on
	// so that an extra output flop is tolerated.
	sequence s_ctrl_wr;
		PSEL && PENABLE && PWRITE && PADDR == 12'h03C;
	endsequence

	a_ma_mode_level: assert property (s_ctrl_wr |-> ##2
		MA_RETURN_ONES == !$past(PWDATA[21], 2)) else $error("ma level");
	a_sec_reset_fwd: assert property (s_ctrl_wr |-> ##2
		SEC_BUS_RESET_N == !($past(PWDATA[22], 2) && !REVERSE_MODE))
		else $error("sec reset");
	a_hot_reset_rev: assert property (s_ctrl_wr |-> ##2
		HOT_RESET == ($past(PWDATA[22], 2) && REVERSE_MODE))
		else $error("hot reset");
	a_parity_cause: assert property (PARITY_RESPOND |->
		$past(SEC_PARITY_ERR) && !REVERSE_MODE) else $error("parity");
	a_poison_cause: assert property (MDPE_SET |->
		$past(POISON_RX) && REVERSE_MODE) else $error("poison");
	a_target_abort: assert property (TARGET_ABORT_REQ |->
		$past(MASTER_ABORT) && $past(MA_CAN_TARGET_ABORT)
		&& !MA_RETURN_ONES) else $error("target abort");
	a_serr_pin_pulse: assert property (SYSTEM_ERROR_PIN_N_OE |->
		$past(MASTER_ABORT) && !$past(MA_CAN_TARGET_ABORT)
		&& $past(SERR_PIN_ENABLE) ##1 !SYSTEM_ERROR_PIN_N_OE)
		else $error("serr pin");
	a_unmapped_err: assert property (PSEL && PENABLE && PADDR == 12'h200
		|-> PSLVERR) else $error("unmapped");
	a_discard_once: assert property (DC_DISCARD |=> !DC_DISCARD)
		else $error("discard");
endmodule

// *** verif/pci_agent_model.sv ***
// Secondary bus agent: drives the error pin and fetches completions.
`timescale 1ns/1ns
module pci_agent_model (
	// Clock.
	input wire logic       clk,
	// Controls from the bench; a take delay of zero never fetches.
	input wire logic       serr_req,
	input wire logic [7:0] take_after,
	// Completion handshake and error pin.
	input wire logic       dc_ready,
	output logic           dc_taken,
	output logic           serr_n
);
	int cnt = 0;

	// The error pin is driven high whenever serr_req is low, so it idles high between events.
	// Each signal gets one assignment per edge, so no late override races.
	always @(posedge clk) begin
		serr_n <= !serr_req;
		dc_taken <= !dc_ready && cnt != 0 && cnt == take_after;
		if (dc_ready) begin
			cnt <= 1;
		end else if (cnt != 0 && cnt == take_after) begin
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt + 1;
		end
	end
	initial begin
		dc_taken = 1'h0;
		serr_n = 1'h1;
	end
endmodule

// *** verif/bridge_control_config_tb_top.sv ***
// Self-checking bench for the bridge control block.
`timescale 1ns/1ns
module bridge_control_config_tb_top;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic        rev, serr_en, can_ta, serr_req, io_win, dc_taken, serr_n;
	logic        dc_dis, io_fwd, mem_fwd, par, mdpe, msg, ta, ones, oe;
	logic        sec_n, hot, irq, seen, mdw, so, mem_win;
	logic [3:0]  ev;
	logic [7:0]  take;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, io_addr, mem_addr;
	int          fail_count = 0;
	int          checked = 0;
	int          n;
	wire  [1:0]  mon = {msg, dc_dis};

	// Short timer lengths keep the run brief.
	bridge_control_config #(.DISCARD_LONG(40), .DISCARD_SHORT(8)) dut (
		.SYS_CLK(clk), .RST_N(rst_n), .CE(1'h1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.REVERSE_MODE(rev), .IO_ENABLE(1'h1), .MEM_ENABLE(1'h1),
		.SERR_PIN_ENABLE(serr_en), .SEC_SERR_N(serr_n),
		.SEC_PARITY_ERR(ev[0]), .POISON_RX(ev[1]), .MASTER_ABORT(ev[2]),
		.MA_CAN_TARGET_ABORT(can_ta), .DC_READY(ev[3]), .DC_TAKEN(dc_taken),
		.DC_DISCARD(dc_dis), .IO_ADDR(io_addr), .IO_IN_WINDOW(io_win),
		.MEM_ADDR(mem_addr), .MEM_IN_WINDOW(mem_win), .IO_FORWARD(io_fwd),
		.MEM_FORWARD(mem_fwd), .PARITY_RESPOND(par), .MDPE_SET(mdpe),
		.ERR_MSG_REQ(msg), .TARGET_ABORT_REQ(ta), .MA_RETURN_ONES(ones),
		.MA_DISCARD_WRITE(mdw), .SYSTEM_ERROR_PIN_N_O(so),
		.SYSTEM_ERROR_PIN_N_OE(oe), .SEC_BUS_RESET_N(sec_n),
		.HOT_RESET(hot), .IRQ(irq));
	pci_agent_model agent (.clk(clk), .serr_req(serr_req),
		.take_after(take), .dc_ready(ev[3]), .dc_taken(dc_taken),
		.serr_n(serr_n));

	// Free-running 20 MHz clock.
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	// One APB transfer; nothing is released before pready is seen high or 20 cycles pass.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
		if (k >= 20) begin
			fail_count++;
			stop_test();
		end
	endtask

	// Raises one event input for exactly one cycle.
	task automatic fire(input int i);
		@(posedge clk);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev[i] <= 1'h0;
		#1;
	endtask

	// Counts cycles until a watched output rises, bounded by lim.
	task automatic wait_for(input int i, input int lim);
		n = 0;
		while (mon[i] !== 1'h1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			stop_test();
		end
	endtask

	task automatic do_reset(input logic mode);
		@(posedge clk);
		rst_n <= 1'h0;
		rev <= mode;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Forward mode first, then the strap is flipped and reset repeated.
	initial begin
		{psel, penable, pwrite, serr_en, can_ta, serr_req, io_win} = '0;
		mem_win = 1'h0;
		{ev, take, paddr, pwdata, io_addr, mem_addr, rst_n, rev} = '0;
		do_reset(1'h0);
		apb(1'h0, 12'h03C, 32'h0);
		chk("ctrl rst", rd, 32'h0);
		chk("ones", ones, 1);
		chk("drop wr", mdw, 1);
		apb(1'h1, 12'h03C, 32'hFFFFFFFF);
		apb(1'h0, 12'h03C, 32'h0);
		chk("ctrl fwd", rd, 32'h007F00FF);
		chk("sec rst", {sec_n, hot, ones}, 0);
		chk("keep wr", mdw, 0);
		apb(1'h1, 12'h03C, 32'h003F0000);
		fire(0);
		chk("parity", par, 1);
		apb(1'h0, 12'h100, 32'h0);
		chk("status", rd, 32'h2);
		apb(1'h1, 12'h104, 32'h2);
		chk("irq on", irq, 1);
		apb(1'h1, 12'h100, 32'h2);
		chk("irq off", irq, 0);
		@(posedge clk);
		can_ta <= 1'h1;
		fire(2);
		chk("ta", ta, 1);
		@(posedge clk);
		can_ta <= 1'h0;
		serr_en <= 1'h1;
		fire(2);
		chk("serr oe", oe, 1);
		chk("serr lvl", so, 0);
		@(posedge clk);
		serr_req <= 1'h1;
		wait_for(1, 8);
		chk("err msg", msg, 1);
		@(posedge clk);
		serr_req <= 1'h0;
		io_win <= 1'h1;
		io_addr <= 32'h0F0;
		#1 chk("isa low", io_fwd, 0);
		@(posedge clk);
		io_addr <= 32'h1F0;
		#1 chk("isa top", io_fwd, 1);
		@(posedge clk);
		io_win <= 1'h0;
		io_addr <= 32'h13C0;
		#1 chk("vga16", io_fwd, 0);
		@(posedge clk);
		mem_addr <= 32'h000A0000;
		#1 chk("vga mem", mem_fwd, 1);
		// VGA on, 10-bit decode, parity response off for the next check.
		apb(1'h1, 12'h03C, 32'h012E0000);
		chk("vga10", {io_fwd, mem_fwd}, 3);
		@(posedge clk);
		mem_addr <= 32'h000C0000;
		mem_win <= 1'h1;
		#1 chk("mem win", mem_fwd, 1);
		fire(0);
		chk("no parity", par, 0);
		fire(3);
		wait_for(0, 60);
		chk("long", n, 40);
		apb(1'h0, 12'h03C, 32'h0);
		chk("mto", rd[26], 1);
		apb(1'h1, 12'h03C, 32'h04270000);
		apb(1'h0, 12'h03C, 32'h0);
		chk("mto clr", rd[26], 0);
		take = 8'h05;
		seen = 1'h0;
		fire(3);
		repeat (50) begin
			@(posedge clk);
			#1 seen |= dc_dis;
		end
		chk("taken", seen, 0);
		take = 8'h00;
		apb(1'h0, 12'h200, 32'h0);
		chk("slverr", err, 1);
		chk("unmapped", rd, 0);
		do_reset(1'h1);
		apb(1'h0, 12'h03C, 32'h0);
		chk("ctrl rev", rd, 32'h00000100);
		apb(1'h1, 12'h03C, 32'hFFFFFFFF);
		apb(1'h0, 12'h03C, 32'h0);
		chk("ctrl rev", rd, 32'h017D01FF);
		chk("hot", {hot, sec_n}, 3);
		fire(1);
		chk("mdpe", mdpe, 1);
		fire(3);
		wait_for(0, 60);
		chk("short", n, 8);
		stop_test();
	end
endmodule

bind bridge_control_config bridge_control_config_checker chk_i (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
	.REVERSE_MODE(REVERSE_MODE), .SERR_PIN_ENABLE(SERR_PIN_ENABLE),
	.SEC_PARITY_ERR(SEC_PARITY_ERR), .POISON_RX(POISON_RX),
	.MASTER_ABORT(MASTER_ABORT), .MA_CAN_TARGET_ABORT(MA_CAN_TARGET_ABORT),
	.PARITY_RESPOND(PARITY_RESPOND), .MDPE_SET(MDPE_SET),
	.TARGET_ABORT_REQ(TARGET_ABORT_REQ), .MA_RETURN_ONES(MA_RETURN_ONES),
	.SYSTEM_ERROR_PIN_N_OE(SYSTEM_ERROR_PIN_N_OE),
	.SEC_BUS_RESET_N(SEC_BUS_RESET_N), .HOT_RESET(HOT_RESET),
	.DC_DISCARD(DC_DISCARD));
